// file: pkg/logic_cluster_map.svh
// Register offsets, field positions and reset values of the logic cluster.
// Assumes a 32-bit APB slave, byte addresses, one aligned word per register.
`ifndef LOGIC_CLUSTER_MAP_SVH
`define LOGIC_CLUSTER_MAP_SVH

`define LC_NUM_CELLS      10
`define LC_OFF_CTRL       8'h00
`define LC_OFF_STATUS     8'h04
`define LC_OFF_MASK_BASE  8'h08
`define LC_OFF_CFG_BASE   8'h30
`define LC_CTRL_RESET     32'h0000_0080
`define LC_CFG_RESET      13'h0000
`define LC_MASK_RESET     16'h0000
`define LC_CTRL_CLKA_LSB  0
`define LC_CTRL_CLKB_LSB  3
`define LC_CTRL_CLKB_FALL 6
`define LC_CTRL_CHIPCLR   7

`endif

// file: pkg/logic_cluster_pkg.sv
// Types shared by the logic cluster design.
// Assumes logic_cluster_map.svh for offsets and reset values.
package logic_cluster_pkg;

  // Register behaviour of a logic cell
  typedef enum logic [1:0] {
    FF_D,
    FF_T,
    FF_JK,
    FF_SR
  } ff_mode_t;

  // Cluster-wide control lines taken from local interconnect
  typedef struct packed {
    logic addnsub;
    logic sload;
    logic sclr;
    logic aload;
    logic aclr1;
    logic aclr0;
    logic ena_b;
    logic ena_a;
  } ctrl_t;

  // Per-cell configuration word
  typedef struct packed {
    logic [2:0] out_src;   // [2] local, [1] route b, [0] route a; 1 = register
    logic       arith;
    logic       reg_chain;
    logic       lut_chain;
    logic       pack_fb;
    logic       use_sync;
    logic       use_aload;
    logic       aclr_sel;
    logic       clk_sel;
    ff_mode_t   mode;
  } cell_cfg_t;

endpackage : logic_cluster_pkg

// file: verilog/logic_cluster.sv
// Logic cluster of ten logic cells with shared control, cascades and add/sub.
// Assumes row clocks and control lines are synchronous to pclk; configured
// through APB.
`include "logic_cluster_map.svh"

module logic_cluster (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic [7:0]                     row_clk,
  input  wire logic_cluster_pkg::ctrl_t       local_ctrl,
  input  wire logic [`LC_NUM_CELLS-1:0][3:0]  cell_in,
  input  wire logic                           carry_in,
  input  wire logic                           chip_wide_clear_n,
  output logic      [`LC_NUM_CELLS-1:0]       out_route_a,
  output logic      [`LC_NUM_CELLS-1:0]       out_route_b,
  output logic      [`LC_NUM_CELLS-1:0]       out_local,
  output logic      [`LC_NUM_CELLS-1:0]       lut_chain_out,
  output logic      [`LC_NUM_CELLS-1:0]       reg_chain_out,
  output logic                                carry_out
);
  import logic_cluster_pkg::*;

  localparam int N = `LC_NUM_CELLS;

  // Decode a per-cell register; returns N when the address misses the bank
  function automatic logic [3:0] cell_index(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] rel;
    rel = addr - base;
    if (addr >= base && rel[1:0] == 2'b00 && rel[7:2] < 6'(N)) begin
      cell_index = rel[5:2];
    end else begin
      cell_index = 4'(N);
    end
  endfunction : cell_index

  logic [31:0]     ctrl_q;
  logic [15:0]     mask_q [N];
  cell_cfg_t       cfg_q  [N];
  logic [N-1:0]    reg_q, reg_d;
  logic [N-1:0]    lut_res;
  logic [N:0]      carry;
  logic [7:0]      row_prev_q;
  logic            tick_a, tick_b, chip_clr;
  logic [N-1:0]    clr_hit, load_hit, tick_hit;
  logic [3:0]      wr_mask_idx, wr_cfg_idx, rd_mask_idx, rd_cfg_idx;
  logic            wr_en, mapped;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: the answer is ready in every access phase
  assign pready      = 1'b1;
  assign wr_en       = psel && penable && pwrite;
  assign wr_mask_idx = cell_index(paddr, `LC_OFF_MASK_BASE);
  assign wr_cfg_idx  = cell_index(paddr, `LC_OFF_CFG_BASE);
  assign rd_mask_idx = wr_mask_idx;
  assign rd_cfg_idx  = wr_cfg_idx;
  assign mapped      = (paddr == `LC_OFF_CTRL) || (paddr == `LC_OFF_STATUS)
                    || (wr_mask_idx != 4'(N)) || (wr_cfg_idx != 4'(N));
  assign pslverr     = psel && penable && !mapped;

  // Configuration writes; unmapped writes change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `LC_CTRL_RESET;
      for (int i = 0; i < N; i++) begin
        mask_q[i] <= `LC_MASK_RESET;
        cfg_q[i]  <= cell_cfg_t'(`LC_CFG_RESET);
      end
    end else if (wr_en) begin
      if (paddr == `LC_OFF_CTRL) begin
        ctrl_q <= {24'h00_0000, pwdata[7:0]};
      end else if (wr_mask_idx != 4'(N)) begin
        mask_q[wr_mask_idx] <= pwdata[15:0];
      end else if (wr_cfg_idx != 4'(N)) begin
        cfg_q[wr_cfg_idx] <= cell_cfg_t'(pwdata[12:0]);
      end
    end
  end

  // Read data captured in the setup phase so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `LC_OFF_CTRL) begin
        prdata <= ctrl_q;
      end else if (paddr == `LC_OFF_STATUS) begin
        prdata <= {22'h00_0000, reg_q};
      end else if (rd_mask_idx != 4'(N)) begin
        prdata <= {16'h0000, mask_q[rd_mask_idx]};
      end else if (rd_cfg_idx != 4'(N)) begin
        prdata <= {19'h0_0000, cfg_q[rd_cfg_idx]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Cluster clocks and shared control
  // ---------------------------------------------------------------
  // Row clocks are sampled levels; their edges become one-cycle ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_prev_q <= 8'h00;
    end else begin
      row_prev_q <= row_clk;
    end
  end

  // Each clock is gated only by its own enable
  always_comb begin
    logic [2:0] sa;
    logic [2:0] sb;
    sa     = ctrl_q[`LC_CTRL_CLKA_LSB +: 3];
    sb     = ctrl_q[`LC_CTRL_CLKB_LSB +: 3];
    tick_a = row_clk[sa] && !row_prev_q[sa] && local_ctrl.ena_a;
    // Falling-edge use spends the second cluster clock
    if (ctrl_q[`LC_CTRL_CLKB_FALL]) begin
      tick_b = !row_clk[sb] && row_prev_q[sb] && local_ctrl.ena_b;
    end else begin
      tick_b = row_clk[sb] && !row_prev_q[sb] && local_ctrl.ena_b;
    end
  end

  // Chip-wide clear is an option bit so it can be left unused
  assign chip_clr = !chip_wide_clear_n && ctrl_q[`LC_CTRL_CHIPCLR];

  // ---------------------------------------------------------------
  // Lookup tables, carry chain and register next state
  // ---------------------------------------------------------------
  // Cells are evaluated low to high so both cascades ripple upward
  always_comb begin
    logic [3:0] idx;
    logic       b_op, din, q, aclr, f;
    idx      = 4'h0;
    b_op     = 1'b0;
    din      = 1'b0;
    q        = 1'b0;
    aclr     = 1'b0;
    f        = 1'b0;
    carry[0] = local_ctrl.addnsub ? 1'b1 : carry_in;
    for (int i = 0; i < N; i++) begin
      q   = reg_q[i];
      idx = cell_in[i];
      if (cfg_q[i].lut_chain && i > 0) begin
        idx[0] = lut_res[i-1];
      end
      if (cfg_q[i].pack_fb) begin
        idx[3] = q;
      end
      b_op = cell_in[i][1] ^ local_ctrl.addnsub;
      if (cfg_q[i].arith) begin
        lut_res[i]  = cell_in[i][0] ^ b_op ^ carry[i];
        carry[i+1]  = (cell_in[i][0] & b_op) | (carry[i] & (cell_in[i][0] ^ b_op));
      end else begin
        lut_res[i]  = mask_q[i][idx];
        carry[i+1]  = carry[i];
      end
      din  = (cfg_q[i].reg_chain && i > 0) ? reg_q[i-1] : lut_res[i];
      aclr = cfg_q[i].aclr_sel ? local_ctrl.aclr1 : local_ctrl.aclr0;
      tick_hit[i] = cfg_q[i].clk_sel ? tick_b : tick_a;
      clr_hit[i]  = aclr;
      load_hit[i] = cfg_q[i].use_aload && local_ctrl.aload;
      case (cfg_q[i].mode)
        FF_D:    f = din;
        FF_T:    f = q ^ din;
        FF_JK:   f = (din & ~q) | (~cell_in[i][2] & q);
        default: f = din | (~cell_in[i][2] & q);
      endcase
      // Clear outranks load; sync controls only act on a clock tick
      if (chip_clr) begin
        reg_d[i] = 1'b0;
      end else if (aclr) begin
        reg_d[i] = 1'b0;
      end else if (load_hit[i]) begin
        reg_d[i] = cell_in[i][3];
      end else if (!tick_hit[i]) begin
        reg_d[i] = q;
      end else if (cfg_q[i].use_sync && local_ctrl.sclr) begin
        reg_d[i] = 1'b0;
      end else if (cfg_q[i].use_sync && local_ctrl.sload) begin
        reg_d[i] = cell_in[i][3];
      end else begin
        reg_d[i] = f;
      end
    end
  end

  // Cell registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q <= '0;
    end else begin
      reg_q <= reg_d;
    end
  end

  // ---------------------------------------------------------------
  // Cell outputs
  // ---------------------------------------------------------------
  // Outputs are retimed once; this adds a cycle but keeps them glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_route_a   <= '0;
      out_route_b   <= '0;
      out_local     <= '0;
      lut_chain_out <= '0;
      reg_chain_out <= '0;
      carry_out     <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        out_route_a[i] <= cfg_q[i].out_src[0] ? reg_q[i] : lut_res[i];
        out_route_b[i] <= cfg_q[i].out_src[1] ? reg_q[i] : lut_res[i];
        out_local[i]   <= cfg_q[i].out_src[2] ? reg_q[i] : lut_res[i];
      end
      lut_chain_out <= lut_res;
      reg_chain_out <= reg_q;
      carry_out     <= carry[N];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_CHIP_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    chip_clr |=> reg_q == '0) else $error("chip clear left a register set");

  AST_CLEAR_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (clr_hit & load_hit) != '0 |=> (reg_q & $past(clr_hit & load_hit)) == '0)
    else $error("load beat clear");

  AST_PRESET: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && load_hit[0] && !clr_hit[0] && cell_in[0][3] |=> reg_q[0])
    else $error("preset failed on cell zero");

  AST_GATED_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && (tick_hit | clr_hit | load_hit) == '0 |=> $stable(reg_q))
    else $error("register moved without a clock tick");

  AST_SUB_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    local_ctrl.addnsub |-> carry[0]) else $error("subtract carry-in not one");

  AST_SUM_CELL0: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[0].arith |-> lut_res[0] ==
      (cell_in[0][0] ^ cell_in[0][1] ^ local_ctrl.addnsub ^ carry[0]))
    else $error("cell zero sum wrong");

  AST_REG_SHIFT: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && tick_hit[1] && !clr_hit[1] && !load_hit[1] && !local_ctrl.sclr
      && !local_ctrl.sload && cfg_q[1].reg_chain && cfg_q[1].mode == FF_D
      |=> reg_q[1] == $past(reg_q[0])) else $error("register chain did not shift");

  AST_BYPASS: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_q[0].out_src[0] |=> out_route_a[0] == $past(lut_res[0]))
    else $error("bypass output not lookup result");

  AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && tick_hit[0] && !clr_hit[0] && !load_hit[0] && !cfg_q[0].use_sync
      && cfg_q[0].mode == FF_T && !cfg_q[0].reg_chain && lut_res[0]
      |=> reg_q[0] != $past(reg_q[0])) else $error("T register did not toggle");

  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && mapped |-> pready && !pslverr) else $error("mapped access errored");

  // Cascade, packing and shared-control checks on the low cells; enable gating on all cells
  AST_LUT_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[1].lut_chain && !cfg_q[1].arith && !cfg_q[1].pack_fb
      |-> lut_res[1] == mask_q[1][{cell_in[1][3:1], lut_res[0]}])
    else $error("lookup chain not fed from cell zero");

  AST_PACK: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[0].pack_fb && !cfg_q[0].arith
      |-> lut_res[0] == mask_q[0][{reg_q[0], cell_in[0][2:0]}])
    else $error("packed register not at input four");

  AST_FALL_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[`LC_CTRL_CLKB_FALL] && tick_b |-> !row_clk[ctrl_q[`LC_CTRL_CLKB_LSB +: 3]])
    else $error("falling clock ticked on a high row");

  AST_ENABLE_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !local_ctrl.ena_a && !local_ctrl.ena_b |-> tick_hit == '0)
    else $error("clock ticked with both enables low");

  AST_SYNC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && tick_hit[0] && !clr_hit[0] && !load_hit[0] && cfg_q[0].use_sync
      && local_ctrl.sclr |=> !reg_q[0]) else $error("sync clear ignored on cell zero");

  AST_ALOAD_DATA: assert property (@(posedge pclk) disable iff (!presetn)
    !chip_clr && load_hit[0] && !clr_hit[0] |=> reg_q[0] == $past(cell_in[0][3]))
    else $error("async load data not input four");

  AST_ROUTE_REG: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[0].out_src[1] |=> out_route_b[0] == $past(reg_q[0]))
    else $error("route b not from register");

  COV_SUBTRACT: cover property (@(posedge pclk) disable iff (!presetn)
    local_ctrl.addnsub && cfg_q[0].arith);
  COV_FALL_EDGE: cover property (@(posedge pclk) disable iff (!presetn)
    tick_b && ctrl_q[`LC_CTRL_CLKB_FALL]);
  COV_CLEAR_LOAD: cover property (@(posedge pclk) disable iff (!presetn)
    (clr_hit & load_hit) != '0);
  // Packing and sync clear are the least obvious paths
  COV_PACK: cover property (@(posedge pclk) disable iff (!presetn)
    cfg_q[0].pack_fb);
  COV_SYNC_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
    tick_hit[0] && cfg_q[0].use_sync && local_ctrl.sclr);

endmodule : logic_cluster

// file: tb/row_clock_model.sv
// Row clock source standing in for the surrounding routing.
// Assumes the bench pulses req for one pclk cycle per wanted edge.
module row_clock_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       req,
  input  wire logic [2:0] sel,
  output logic      [7:0] row_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_q;
  // ------------------------------------------------------------------
  // Pulse shaping
  // ------------------------------------------------------------------
  // Two-cycle high so the sampled edge detector sees one clean rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 2'h0;
    end else if (req) begin
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // Unused rows stay low between pulses
  assign row_clk = (hold_q != 2'h0) ? (8'h01 << sel) : 8'h00;
endmodule : row_clock_model

// file: tb/logic_cluster_tb.sv
// Self-checking bench for the logic cluster, driven over APB.
// Assumes the row clock model pulses the row clock picked by row_sel.
`include "logic_cluster_map.svh"
module logic_cluster_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import logic_cluster_pkg::*;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic             pwrite = 1'b0, req = 1'b0, carry_in = 1'b0, chip_wide_clear_n = 1'b1;
  logic [7:0]       paddr = 8'h00, row_clk;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, err, carry_out;
  ctrl_t            local_ctrl = '0;
  logic [2:0]       row_sel = 3'h0;
  logic [9:0][3:0]  cell_in = '0;
  logic [9:0]       out_route_a, out_route_b, out_local, lut_chain_out, reg_chain_out;
  int               fail_count = 0, total_checks = 0, cyc = 0;
  // Mode table: {mode, inputs, expected register}; data is input zero
  logic [6:0]       tbl [12] = '{7'h00, 7'h03, 7'h22, 7'h20, 7'h23, 7'h48,
                                 7'h43, 7'h4A, 7'h40, 7'h63, 7'h68, 7'h6B};

  logic_cluster i_logic_cluster (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .row_clk(row_clk), .local_ctrl(local_ctrl),
    .cell_in(cell_in), .carry_in(carry_in), .chip_wide_clear_n(chip_wide_clear_n),
    .out_route_a(out_route_a), .out_route_b(out_route_b), .out_local(out_local),
    .lut_chain_out(lut_chain_out), .reg_chain_out(reg_chain_out), .carry_out(carry_out));
  row_clock_model i_row_clock_model (.pclk(pclk), .presetn(presetn), .req(req),
    .sel(row_sel), .row_clk(row_clk));

  // ------------------------------------------------------------------
  // Clock, timeout and helpers
  // ------------------------------------------------------------------
  always #2 pclk = ~pclk;
  // Cuts a hang short; tests need far fewer cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  function automatic logic [7:0] cfg_a(input int i);
    return `LC_OFF_CFG_BASE + 8'(4 * i);
  endfunction : cfg_a
  function automatic logic [7:0] mask_a(input int i);
    return `LC_OFF_MASK_BASE + 8'(4 * i);
  endfunction : mask_a
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic st(input string nm, input logic [9:0] e);
    apb(1'b0, `LC_OFF_STATUS, 32'h0);
    chk(nm, 32'(e), 32'(rd[9:0]));
  endtask : st
  // One row clock rise, then time for register and outputs to land
  task automatic tick();
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask : tick
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin : main
    logic [3:0] a;
    logic [3:0] b;
    logic [4:0] e5;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values; tenth cell exists, an eleventh does not
    apb(1'b0, `LC_OFF_CTRL, 32'h0);
    chk("ctrl", `LC_CTRL_RESET, rd);
    apb(1'b0, cfg_a(9), 32'h0);
    chk("cfg9", 32'(`LC_CFG_RESET), rd);
    apb(1'b0, mask_a(9), 32'h0);
    chk("mask9", 32'(`LC_MASK_RESET), rd);
    apb(1'b1, `LC_OFF_STATUS, 32'h3FF);
    st("status ro", 10'h000);
    apb(1'b1, cfg_a(10), 32'h1);
    chk("cell10 err", 32'h1, 32'(err));
    apb(1'b0, cfg_a(10), 32'h0);
    chk("cell10 data", 32'h0, rd);
    // Parity truth table on cell 2, all outputs from the lookup
    apb(1'b1, mask_a(2), 32'h6996);
    for (int k = 0; k < 16; k++) begin
      cell_in[2] <= 4'(k);
      settle();
      chk("lut", 32'({3{^k[3:0]}}), 32'({out_local[2], out_route_b[2], out_route_a[2]}));
    end
    // Register modes walked through a table on cell 0
    apb(1'b1, mask_a(0), 32'hAAAA);
    local_ctrl.ena_a <= 1'b1;
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, cfg_a(0), 32'h1C00 | 32'(tbl[k][6:5]));
      cell_in[0] <= tbl[k][4:1];
      tick();
      st("mode", 10'(tbl[k][0]));
    end
    // Enable A low gates clock A even with enable B high
    apb(1'b1, cfg_a(0), 32'h1400);
    cell_in[0] <= 4'h1;
    tick();
    local_ctrl.ena_a <= 1'b0;
    local_ctrl.ena_b <= 1'b1;
    cell_in[0] <= 4'h0;
    tick();
    chk("gate", 32'h5, 32'({out_local[0], out_route_b[0], out_route_a[0]}));
    // Asynchronous clear, load and chip clear priorities
    apb(1'b1, cfg_a(0), 32'h1C10);
    cell_in[0] <= 4'h8;
    local_ctrl.aclr0 <= 1'b1;
    local_ctrl.aload <= 1'b1;
    settle();
    st("clr wins", 10'h000);
    local_ctrl.aclr0 <= 1'b0;
    local_ctrl.aclr1 <= 1'b1;
    settle();
    st("preset", 10'h001);
    cell_in[0] <= 4'h0;
    settle();
    st("aload data", 10'h000);
    cell_in[0] <= 4'h8;
    chip_wide_clear_n <= 1'b0;
    settle();
    st("chip clr", 10'h000);
    apb(1'b1, `LC_OFF_CTRL, 32'h0);
    settle();
    st("chip clr off", 10'h001);
    chip_wide_clear_n <= 1'b1;
    local_ctrl <= '0;
    // Four-bit add and subtract across cells 0 to 3
    for (int i = 0; i < 4; i++) apb(1'b1, cfg_a(i), 32'h0200);
    for (int k = 0; k < 8; k++) begin
      a = 4'(k * 5 + 3);
      b = 4'(k * 7 + 1);
      local_ctrl.addnsub <= k[0];
      carry_in <= ~k[0];
      for (int i = 0; i < 4; i++) cell_in[i] <= {2'h0, b[i], a[i]};
      settle();
      e5 = {1'b0, a} + {1'b0, k[0] ? ~b : b} + 5'h01;
      chk("addsub", 32'(e5), 32'({carry_out, out_route_a[3:0]}));
    end
    // Register chain shift and lookup chain into cell 1
    local_ctrl <= ctrl_t'(8'h01);
    apb(1'b1, cfg_a(0), 32'h1C00);
    apb(1'b1, mask_a(1), 32'hAAAA);
    apb(1'b1, cfg_a(1), 32'h1980);
    cell_in <= 40'h00_0000_0001;
    tick();
    cell_in[0] <= 4'h0;
    tick();
    st("reg chain", 10'h002);
    chk("reg chain out", 32'h2, 32'(reg_chain_out[1:0]));
    cell_in[0] <= 4'h1;
    settle();
    chk("lut chain", 32'h3, 32'({out_route_a[1], lut_chain_out[0]}));
    // Clock B on row 1, falling edge; a rise alone must not load cell 0
    local_ctrl <= ctrl_t'(8'h02);
    apb(1'b1, `LC_OFF_CTRL, 32'h0000_0048);
    apb(1'b1, cfg_a(0), 32'h0000_1C04);
    row_sel <= 3'h1;
    tick();
    st("clk b tick", 10'h003);
    req <= 1'b1;
    @(posedge pclk);
    req <= 1'b0;
    repeat (2) @(posedge pclk);
    cell_in[0] <= 4'h0;
    repeat (4) @(posedge pclk);
    st("clk b fall", 10'h002);
    row_sel <= 3'h0;
    cell_in[0] <= 4'h1;
    tick();
    st("row select", 10'h002);
    // Packed register feeds input four of its own lookup
    apb(1'b1, mask_a(0), 32'h0000_FF00);
    apb(1'b1, cfg_a(0), 32'h0000_0040);
    cell_in[0] <= 4'h8;
    settle();
    chk("pack", 32'h0, 32'(out_route_a[0]));
    // Sync clear outranks data only where a cell opts in
    local_ctrl <= ctrl_t'(8'h01);
    apb(1'b1, cfg_a(0), 32'h0000_1C20);
    tick();
    st("sync off", 10'h001);
    local_ctrl <= ctrl_t'(8'h21);
    tick();
    st("sync clr", 10'h002);
    complete_run();
  end
endmodule : logic_cluster_tb
